// file: design/srbc_pkg.sv
// Purpose: Constants and types for the SDRAM refresh, mode setting and bus control block.
// Assumes: APB register access, one 250 MHz clock, asynchronous active-low reset.
// Notes: Register layout and field positions below are fixed for this block.
// Notes on behaviour
// (R1) Both refresh bits set: self-refresh, clock-enable low
// (R2) Clearing mode select exits; wait precharge cycles
// (R3) Auto-refresh resumes when control set, mode clear
// (R4) Self-refresh persists until cleared or power-on
// (R5) Power-on reset clears registers and self-refresh
// (R6) Software: clear control, zero counter, set both
// (R7) Refresh waits for bus cycle or reacquired bus
// (R8) Newer compare match replaces pending refresh
// (R9) Pending refresh or interrupt drives reclaim low
// (R10) Refresh start without interrupt releases reclaim
// (R11) Byte write to mode window programs mode
// (R12) Mode write: precharge-all, then mode-set command
// (R13) Mode-set address pattern, shifted for 16-bit bus
// (R14) Software keeps power-up idle before mode setting
// (R15) Software runs dummy auto-refresh cycles after setting
// (R16) Nonzero burst count makes area burst ROM
// (R17) Burst length 4/8/16 limited by ROM width
// (R18) Wait sampled first beat only if waits set
// (R19) Zero-wait burst: later beats take two cycles
// (R20) Idle cycles on area change or read-then-write
// (R21) Idle count minus empty cycles; none after arbitration
// (R22) Release bus between cycles, never inside locked sequences
// (R23) External master holds request until grant, drops on reclaim
package srbc_pkg;
  localparam logic [11:0] REG_MEMCTL = 12'h000;
  localparam logic [11:0] REG_RFCNT = 12'h004;
  localparam logic [11:0] REG_RFCMP = 12'h008;
  localparam logic [11:0] REG_BUSCTL = 12'h00C;
  localparam logic [11:0] REG_IDLECTL = 12'h010;
  localparam logic [11:0] REG_STATUS = 12'h014;
  // Memory control fields.
  localparam int MC_RMS = 0;
  localparam int MC_RC = 1;
  localparam int MC_TPC = 2;
  localparam int MC_BUS16 = 4;
  // Bus control fields: burst counts of areas 0, 5, 6, ROM width, wait states.
  localparam int BC_A0 = 0;
  localparam int BC_A5 = 2;
  localparam int BC_A6 = 4;
  localparam int BC_WID = 6;
  localparam int BC_WAIT = 8;
  localparam int ADDR_AREA = 26;
  localparam logic [19:0] MODE_WIN2 = 20'hFFFFD;
  localparam logic [19:0] MODE_WIN3 = 20'hFFFFE;
  localparam logic [6:0] MRS_OPCODE = 7'h04;
  localparam logic [4:0] MEMCTL_RST = 5'h00;
  localparam logic [7:0] RFCNT_RST = 8'h00;
  localparam logic [7:0] RFCMP_RST = 8'h00;
  localparam logic [11:0] BUSCTL_RST = 12'h000;
  localparam logic [13:0] IDLECTL_RST = 14'h0000;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_PALL = 3'h1,
    CMD_REF = 3'h2,
    CMD_MRS = 3'h3,
    CMD_SREF = 3'h4
  } srbc_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_GAP = 4'h1,
    ST_ACC = 4'h3,
    ST_REFR = 4'h2,
    ST_RWAIT = 4'h6,
    ST_MPRE = 4'h7,
    ST_MWR = 4'h5,
    ST_SELF = 4'h4,
    ST_SXIT = 4'hC,
    ST_REL = 4'hD
  } srbc_state_t;

  typedef struct packed {
    srbc_state_t st;
    logic [7:0] cnt;
    logic [4:0] beat;
    logic [4:0] nbeat;
    logic burst;
    logic [2:0] area;
    logic cur_read;
    logic [2:0] last_area;
    logic last_read;
    logic [3:0] gap;
    logic after_rel;
    logic pend;
    logic [4:0] memory_control;
    logic [7:0] refresh_counter;
    logic [7:0] refresh_compare_value;
    logic [11:0] bcr;
    logic [13:0] wcr;
    logic w1;
    logic w2;
    logic b1;
    logic b2;
    logic cke;
    logic cs_n;
    srbc_cmd_t cmd;
    logic [15:0] maddr;
    logic grant_n;
    logic reclaim_n;
    logic ack;
    logic last;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } srbc_regs_t;

  localparam srbc_regs_t SRBC_REGS_RST = '{st: ST_IDLE, cmd: CMD_NOP, memory_control: MEMCTL_RST, refresh_counter: RFCNT_RST,
    refresh_compare_value: RFCMP_RST, bcr: BUSCTL_RST, wcr: IDLECTL_RST, w1: 1'b1, w2: 1'b1, b1: 1'b1, b2: 1'b1, cke: 1'b1,
    cs_n: 1'b1, grant_n: 1'b1, reclaim_n: 1'b1, after_rel: 1'b1, default: '0};
endpackage

// file: design/srbc_top.sv
// Purpose: SDRAM self-refresh and auto-refresh sequencing, mode setting, burst ROM and bus arbitration.
// Assumes: Requests come from logic on i_clk; wait and release-request pins are asynchronous.
// Notes: All outputs are registered; APB answers in the second access cycle.
`timescale 1ns/1ps
module srbc_top
  import srbc_pkg::*;
(
  input wire logic i_clk, // 250 MHz clock
  input wire logic i_reset_n, // Power-on reset, async, low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire logic [11:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error on unmapped address
  input wire logic i_req, // Access request, held until last ack
  input wire logic [31:0] i_req_addr, // Access address
  input wire logic i_req_write, // Access is a write
  input wire logic [1:0] i_req_size, // 0 byte, 1 word, 2 longword
  input wire logic i_req_burst, // Read wants a burst ROM fill
  input wire logic i_req_lock, // Locked sequence, no bus release
  input wire logic i_irq_pending, // Interrupt above mask
  input wire logic i_wait_n, // Wait pin, low inserts waits
  input wire logic i_bus_release_req_n, // External bus release request
  output logic o_ack, // One-cycle pulse per finished beat
  output logic o_last, // With o_ack on the final beat
  output logic o_cke, // SDRAM clock enable
  output logic o_cs_n, // Chip select of the current access
  output logic [2:0] o_cmd, // SDRAM command
  output logic [15:0] o_mem_addr, // Address during mode set
  output logic o_bus_grant_n, // Bus grant, low while released
  output logic o_bus_reclaim_request_out_n // Bus reclaim request, low active
);
  srbc_regs_t s;
  srbc_regs_t n;
  logic [31:0] rd;
  logic hit;
  logic auto_mode;
  logic mode_hit;
  logic [3:0] waits;
  logic [4:0] beats;
  logic [1:0] need;
  logic sample;

  // Beats in one burst; a wider ROM caps the length.
  function automatic logic [4:0] burst_beats(input logic [1:0] f, input logic [1:0] wid);
    logic [4:0] b;
    b = 5'h00;
    case (f)
      2'h1: b = 5'h04;
      2'h2: b = 5'h08;
      2'h3: b = 5'h10;
      default: b = 5'h00;
    endcase
    if (b != 5'h00 && wid == 2'h1 && b > 5'h08) begin
      b = 5'h08;
    end
    if (b != 5'h00 && wid == 2'h2) begin
      b = 5'h04;
    end
    return b;
  endfunction

  function automatic logic [1:0] area_burst(input logic [11:0] bcr, input logic [2:0] area);
    case (area)
      3'h0: return bcr[BC_A0 +: 2];
      3'h5: return bcr[BC_A5 +: 2];
      3'h6: return bcr[BC_A6 +: 2];
      default: return 2'h0;
    endcase
  endfunction

  function automatic logic [1:0] idle_of(input logic [13:0] wcr, input logic [2:0] area);
    logic [3:0] idx;
    idx = {area, 1'b0};
    return (area == 3'h7) ? 2'h0 : wcr[idx +: 2];
  endfunction

  always_comb begin
    auto_mode = s.memory_control[MC_RC] && !s.memory_control[MC_RMS];
    waits = s.bcr[BC_WAIT +: 4];
    mode_hit = i_req_write && i_req_size == 2'h0 &&
      (i_req_addr[31:12] == MODE_WIN2 || i_req_addr[31:12] == MODE_WIN3);
    beats = burst_beats(area_burst(s.bcr, i_req_addr[ADDR_AREA +: 3]), s.bcr[BC_WID +: 2]);
    need = 2'h0;
    if (!s.after_rel && (i_req_addr[ADDR_AREA +: 3] != s.last_area || (i_req_write && s.last_read))) begin
      need = idle_of(s.wcr, s.last_area);
    end
    sample = (s.beat != 5'h00) || (waits != 4'h0);
    hit = 1'b1;
    case (i_paddr)
      REG_MEMCTL: rd = {27'h0, s.memory_control};
      REG_RFCNT: rd = {24'h0, s.refresh_counter};
      REG_RFCMP: rd = {24'h0, s.refresh_compare_value};
      REG_BUSCTL: rd = {20'h0, s.bcr};
      REG_IDLECTL: rd = {18'h0, s.wcr};
      REG_STATUS: rd = {24'h0, s.st, s.pend, !s.cke, !s.grant_n, !s.reclaim_n};
      default: begin
        rd = 32'h0;
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    n = s;
    n.w1 = i_wait_n;
    n.w2 = s.w1;
    n.b1 = i_bus_release_req_n;
    n.b2 = s.b1;
    n.ack = 1'b0;
    n.last = 1'b0;
    n.cmd = CMD_NOP;
    if (s.st != ST_ACC && s.gap != 4'hF) begin
      n.gap = s.gap + 4'h1;
    end
    case (s.st)
      ST_IDLE: begin
        // (R1) self-refresh entry
        if (s.memory_control[MC_RC] && s.memory_control[MC_RMS]) begin
          n.st = ST_SELF;
          n.cmd = CMD_SREF;
          n.pend = 1'b0;
        // (R7) refresh only between cycles
        end else if (s.pend) begin
          n.st = ST_REFR;
          n.pend = 1'b0;
          n.cmd = CMD_PALL;
          n.cnt = {6'h00, s.memory_control[MC_TPC +: 2]};
        // (R22) release between cycles
        end else if (!s.b2 && !i_req_lock) begin
          n.st = ST_REL;
          n.after_rel = 1'b1;
        end else if (i_req && !s.ack) begin
          // (R11) mode window write
          if (mode_hit) begin
            n.st = ST_MPRE;
            n.cmd = CMD_PALL;
            // (R13) mode-set address
            n.maddr = s.memory_control[MC_BUS16] ? {1'b0, MRS_OPCODE, i_req_addr[7:5], 5'h00} :
              {MRS_OPCODE, i_req_addr[8:6], 6'h00};
          end else begin
            n.area = i_req_addr[ADDR_AREA +: 3];
            n.cur_read = !i_req_write;
            // (R16) burst ROM area
            n.burst = i_req_burst && !i_req_write && beats != 5'h00;
            // (R17) burst length
            n.nbeat = beats;
            n.beat = 5'h00;
            // (R20) idle insertion
            // (R21) minus empty cycles
            if ({2'h0, need} > s.gap) begin
              n.st = ST_GAP;
              n.cnt = {4'h0, {2'h0, need} - s.gap};
            end else begin
              n.st = ST_ACC;
              n.cnt = {4'h0, waits};
            end
          end
        end
      end
      ST_GAP: begin
        if (s.cnt <= 8'h01) begin
          n.st = ST_ACC;
          n.cnt = {4'h0, waits};
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end
      ST_ACC: begin
        if (s.cnt != 8'h00) begin
          n.cnt = s.cnt - 8'h01;
        // (R18) wait sampling
        end else if (!(sample && !s.w2)) begin
          n.ack = 1'b1;
          if (!s.burst || s.beat == s.nbeat - 5'h01) begin
            n.last = 1'b1;
            n.st = ST_IDLE;
            n.last_area = s.area;
            n.last_read = s.cur_read;
            n.gap = 4'h0;
            n.after_rel = 1'b0;
          end else begin
            n.beat = s.beat + 5'h01;
            // (R19) two cycles minimum
            n.cnt = (waits == 4'h0) ? 8'h01 : {4'h0, waits};
          end
        end
      end
      // (R12) precharge-all then mode set
      ST_MPRE: begin
        n.st = ST_MWR;
        n.cmd = CMD_MRS;
      end
      ST_MWR: begin
        n.st = ST_IDLE;
        n.ack = 1'b1;
        n.last = 1'b1;
      end
      ST_REFR: begin
        if (s.cnt != 8'h00) begin
          n.cnt = s.cnt - 8'h01;
        end else begin
          n.st = ST_RWAIT;
          n.cmd = CMD_REF;
          n.cnt = {6'h00, s.memory_control[MC_TPC +: 2]};
        end
      end
      ST_RWAIT: begin
        if (s.cnt != 8'h00) begin
          n.cnt = s.cnt - 8'h01;
        end else begin
          n.st = ST_IDLE;
        end
      end
      // (R4) stays until mode select cleared
      ST_SELF: begin
        // (R2) exit and quiet wait
        if (!s.memory_control[MC_RMS]) begin
          n.st = ST_SXIT;
          n.cnt = {6'h00, s.memory_control[MC_TPC +: 2]};
        end
      end
      ST_SXIT: begin
        if (s.cnt != 8'h00) begin
          n.cnt = s.cnt - 8'h01;
        end else begin
          n.st = ST_IDLE;
        end
      end
      ST_REL: begin
        // (R23) master drops request to return bus
        if (s.b2) begin
          n.st = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // (R3) counter runs in auto mode
    // (R8) a new match keeps a single pending flag
    if (auto_mode) begin
      if (s.refresh_counter == s.refresh_compare_value) begin
        n.refresh_counter = 8'h00;
        n.pend = 1'b1;
      end else begin
        n.refresh_counter = s.refresh_counter + 8'h01;
      end
    end
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (i_psel && i_penable && !s.pready) begin
      n.pready = 1'b1;
      n.prdata = rd;
      n.pslverr = !hit;
    end
    // Software writes land after the counter update so that they win.
    if (i_psel && i_penable && s.pready && i_pwrite) begin
      case (i_paddr)
        REG_MEMCTL: n.memory_control = i_pwdata[4:0];
        REG_RFCNT: n.refresh_counter = i_pwdata[7:0];
        REG_RFCMP: n.refresh_compare_value = i_pwdata[7:0];
        REG_BUSCTL: n.bcr = i_pwdata[11:0];
        REG_IDLECTL: n.wcr = i_pwdata[13:0];
        default: n.refresh_compare_value = n.refresh_compare_value;
      endcase
    end
    n.cke = (n.st != ST_SELF);
    n.cs_n = (n.st != ST_ACC);
    n.grant_n = (n.st != ST_REL);
    // (R9) reclaim low on pending refresh or interrupt
    // (R10) released once refresh has started
    n.reclaim_n = !(n.pend || i_irq_pending);
  end

  // (R5) power-on reset loads SRBC_REGS_RST: registers cleared, self-refresh exited
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= SRBC_REGS_RST;
    end else begin
      s <= n;
    end
  end

  assign o_prdata = s.prdata;
  assign o_pready = s.pready;
  assign o_pslverr = s.pslverr;
  assign o_ack = s.ack;
  assign o_last = s.last;
  assign o_cke = s.cke;
  assign o_cs_n = s.cs_n;
  assign o_cmd = s.cmd;
  assign o_mem_addr = s.maddr;
  assign o_bus_grant_n = s.grant_n;
  assign o_bus_reclaim_request_out_n = s.reclaim_n;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_self_cke_low: assert property (s.st == ST_SELF |-> !o_cke ##0 (o_cs_n && o_bus_grant_n)) // R1
    else $error("clock enable or select active in self-refresh");
  a_self_no_cmd: assert property (s.st == ST_SELF && $past(s.st) == ST_SELF |-> o_cmd == CMD_NOP) // R1
    else $error("command issued during self-refresh");
  a_exit_quiet: assert property (s.st == ST_SELF && !s.memory_control[MC_RMS] |=> (o_cmd == CMD_NOP && o_cke) [*2]) // R2
    else $error("command issued in self-refresh exit wait");
  a_reclaim_low: assert property (s.pend |-> !o_bus_reclaim_request_out_n) // R9
    else $error("reclaim not driven low for pending refresh");
  a_reclaim_release: assert property (s.st == ST_REFR && !s.pend && !$past(i_irq_pending) |-> // R10
    o_bus_reclaim_request_out_n)
    else $error("reclaim still low after refresh start");
  a_no_refresh_released: assert property (s.st == ST_REL |=> s.st != ST_REFR) // R7
    else $error("refresh started while bus released");
  a_mode_sequence: assert property (s.st == ST_MPRE |-> o_cmd == CMD_PALL ##1 o_cmd == CMD_MRS ##1 o_ack) // R12
    else $error("mode write sequence wrong");
  a_mode_addr: assert property (s.st == ST_MWR && !s.memory_control[MC_BUS16] |-> // R13
    o_mem_addr[15:9] == MRS_OPCODE && o_mem_addr[5:0] == 6'h00)
    else $error("mode-set address pattern wrong");
  a_burst_cs_held: assert property (s.st == ST_ACC && s.burst && o_ack && !o_last |-> !o_cs_n) // R16
    else $error("chip select dropped inside burst");
  a_burst_two_cycle: assert property (o_ack && !o_last |=> !o_ack) // R19
    else $error("burst beat shorter than two cycles");
  a_locked_no_release: assert property (s.st == ST_IDLE && i_req_lock |=> s.st != ST_REL) // R22
    else $error("bus released inside locked sequence");

  c_self_refresh: cover property (s.st == ST_SELF ##[1:50] s.st == ST_SXIT);
  c_refresh_cycle: cover property (s.st == ST_REFR ##[1:10] s.st == ST_RWAIT);
  c_burst_done: cover property (s.burst && o_ack && o_last);
  c_release: cover property (!o_bus_grant_n ##[1:50] o_bus_grant_n);
endmodule // srbc_top

// file: verification/srbc_far_model.sv
// Purpose: External bus master that borrows the bus from the block.
// Assumes: Grant and reclaim come from registered outputs of the block.
// Notes: Wait pin is not modelled here; the bench drives it directly and pulls it low for the wait checks.
`timescale 1ns/1ps
module srbc_far_model (
  input wire logic i_clk, // Clock
  input wire logic i_reset_n, // Reset, active low
  input wire logic i_want, // Bench asks for the bus
  input wire logic i_grant_n, // Grant from the block
  input wire logic i_reclaim_n, // Reclaim from the block
  output logic o_release_req_n // Release request to the block
);
  // hold until grant, drop on reclaim
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_release_req_n <= 1'b1;
    end else if (!i_want || (!i_grant_n && !i_reclaim_n)) begin
      o_release_req_n <= 1'b1;
    end else if (i_reclaim_n) begin
      o_release_req_n <= 1'b0;
    end
  end
endmodule // srbc_far_model

// file: verification/test_sdram_refresh_init_bus_control.sv
// Purpose: Self-checking bench for refresh, mode setting, burst ROM and bus release.
// Assumes: Outputs are sampled at the rising edge, before that edge updates them.
// Notes: Idle-cycle checks compare latencies, so pipeline depth does not matter.
`timescale 1ns/1ps
module test_sdram_refresh_init_bus_control;
  import srbc_pkg::*;
  logic clk, rst_n, psel, pen, pwr, req, rwr, rb, irq, want, brq_n;
  logic rdy, err, rerr, ack, last, cke, cs_n, gnt_n, rcl_n, wt_n, lk;
  logic [11:0] pa;
  logic [31:0] pwd, prd, ra, rdat, lf, x;
  logic [1:0] rsz;
  logic [2:0] cmd;
  logic [15:0] ma;
  logic [2:0] hc[$];
  logic [2:0] mq[$];
  logic hk[$], hr[$], hg[$], ha[$];
  int n_fail, cmp_count, lat, nb, i, j;
  int bc[7] = '{0, 1, 2, 3, 'h43, 'h83, 4};
  int be[7] = '{1, 4, 8, 16, 8, 4, 4};
  srbc_top uut (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_req(req), .i_req_addr(ra),
    .i_req_write(rwr), .i_req_size(rsz), .i_req_burst(rb), .i_req_lock(lk), .i_irq_pending(irq),
    .i_wait_n(wt_n), .i_bus_release_req_n(brq_n), .o_ack(ack), .o_last(last), .o_cke(cke), .o_cs_n(cs_n),
    .o_cmd(cmd), .o_mem_addr(ma), .o_bus_grant_n(gnt_n), .o_bus_reclaim_request_out_n(rcl_n));
  srbc_far_model far (.i_clk(clk), .i_reset_n(rst_n), .i_want(want), .i_grant_n(gnt_n),
    .i_reclaim_n(rcl_n), .o_release_req_n(brq_n));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int fc(logic [2:0] v);
    foreach (hc[k]) if (hc[k] === v) return k;
    return -1;
  endfunction
  function automatic int fb(logic q[$], logic v);
    foreach (q[k]) if (q[k] === v) return k;
    return -1;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(string s, int e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %0h got %0h", s, e, g);
    end
  endtask
  task automatic tmo(logic ok);
    if (ok !== 1'b1) begin
      chk("timeout", 1, 0);
      wrap_up();
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    tmo(rdy);
    rdat = prd;
    rerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // A held request (k) lets the next access follow after only the one empty cycle that carries the last ack.
  task automatic acc(logic [31:0] a, logic w, logic b, logic [1:0] z, logic k);
    int n, p;
    req <= 1'b1;
    ra <= a;
    rwr <= w;
    rb <= b;
    rsz <= z;
    nb = 0;
    mq = {};
    for (n = 1; n < 400; n++) begin
      @(posedge clk);
      if (cmd !== 3'h0) mq.push_back(cmd);
      if (ack === 1'b1) begin
        if (nb == 0) lat = n;
        else chk("beat", 2, n - p);
        p = n;
        nb++;
        if (last === 1'b1) break;
      end else if (nb > 0) chk("cs_hold", 0, cs_n);
    end
    tmo(last);
    if (!k) begin
      req <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic watch(int m);
    hc = {};
    hk = {};
    hr = {};
    hg = {};
    ha = {};
    repeat (m) begin
      @(posedge clk);
      hc.push_back(cmd);
      hk.push_back(cke);
      hr.push_back(rcl_n);
      hg.push_back(gnt_n);
      ha.push_back(ack);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {psel, pen, pwr, req, rwr, rb, irq, want, lk} = '0;
    wt_n = 1'b1;
    pa = '0;
    pwd = '0;
    ra = '0;
    rsz = '0;
    n_fail = 0;
    cmp_count = 0;
    lf = 32'hD109;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), '0);
      chk("reg", 0, rdat);
    end
    apb(1'b0, 12'h018, '0);
    chk("slverr", 1, rerr);
    lf = lfsr(lf);
    apb(1'b1, REG_RFCMP, lf);
    apb(1'b0, REG_RFCMP, '0);
    chk("cmp", int'(lf[7:0]), rdat);
    for (j = 0; j < 2; j++) begin
      apb(1'b1, REG_MEMCTL, j << MC_BUS16);
      for (i = 1; i < 4; i++) begin
        x = (j ? 32'h400 : 32'h800) | (i << (6 - j));
        acc({(i[0] ? MODE_WIN2 : MODE_WIN3), x[11:0]}, 1'b1, 1'b0, 2'h0, 1'b0);
        chk("mode_cmds", 6'h0B, {mq[0], mq[1]});
        chk("mode_addr", x, ma);
      end
    end
    for (i = 0; i < 7; i++) begin
      apb(1'b1, REG_BUSCTL, bc[i]);
      acc(i == 6 ? 32'h1400_0000 : 32'h0, 1'b0, 1'b1, 2'h2, 1'b0);
      chk("beats", be[i], 32'(nb));
    end
    apb(1'b1, REG_BUSCTL, '0);
    apb(1'b1, REG_IDLECTL, 32'h3FFF);
    acc(32'h0400_0000, 1'b0, 1'b0, 2'h2, 1'b1);
    acc(32'h0400_0000, 1'b0, 1'b0, 2'h2, 1'b1);
    i = lat;
    acc(32'h0800_0000, 1'b0, 1'b0, 2'h2, 1'b1);
    chk("gap_area", 1, lat > i);
    acc(32'h0800_0000, 1'b1, 1'b0, 2'h2, 1'b1);
    chk("gap_rw", 1, lat > i);
    acc(32'h0800_0000, 1'b1, 1'b0, 2'h2, 1'b0);
    chk("gap_ww", i, lat);
    repeat (8) @(posedge clk);
    acc(32'h0400_0000, 1'b0, 1'b0, 2'h2, 1'b0);
    chk("gap_empty", i, lat);
    // With no wait states the first access ignores a low wait pin.
    wt_n <= 1'b0;
    acc(32'h0400_0000, 1'b0, 1'b0, 2'h2, 1'b0);
    chk("wait_first", i, lat);
    apb(1'b1, REG_BUSCTL, 32'h100);
    fork
      acc(32'h0400_0000, 1'b0, 1'b0, 2'h2, 1'b0);
      begin
        repeat (6) @(posedge clk);
        wt_n <= 1'b1;
      end
    join
    chk("wait_held", 1, lat > 6);
    apb(1'b1, REG_BUSCTL, '0);
    irq <= 1'b1;
    watch(3);
    chk("rcl_irq", 0, hr[2]);
    irq <= 1'b0;
    watch(3);
    chk("rcl_idle", 1, hr[2]);
    apb(1'b1, REG_RFCMP, 32'h10);
    apb(1'b1, REG_RFCNT, '0);
    apb(1'b1, REG_MEMCTL, 32'h2);
    watch(60);
    j = fc(3'h1);
    chk("rcl_first", 1, fb(hr, 1'b0) >= 0 && fb(hr, 1'b0) < j);
    chk("rcl_start", 1, j >= 0 && hr[j + 1] === 1'b1);
    chk("ref_cmd", 1, fc(3'h2) > j);
    apb(1'b1, REG_MEMCTL, '0);
    lk <= 1'b1;
    want <= 1'b1;
    watch(10);
    chk("lock_grant", 1, hg[9]);
    lk <= 1'b0;
    watch(10);
    chk("grant", 0, hg[9]);
    apb(1'b1, REG_RFCNT, '0);
    apb(1'b1, REG_MEMCTL, 32'h2);
    watch(60);
    i = fb(hg, 1'b1);
    chk("ref_after_bus", 1, i > fb(hr, 1'b0) && fc(3'h1) > i);
    want <= 1'b0;
    apb(1'b1, REG_MEMCTL, 32'h8);
    apb(1'b1, REG_RFCNT, '0);
    apb(1'b1, REG_MEMCTL, 32'hB);
    watch(5);
    chk("sref_cmd", 1, fc(3'h4) >= 0);
    fork
      acc(32'h0400_0000, 1'b0, 1'b0, 2'h2, 1'b0);
      begin
        watch(30);
        chk("sref_hold", 1, hk[29] === 1'b0 && fb(ha, 1'b1) < 0);
        apb(1'b1, REG_MEMCTL, 32'hA);
        watch(60);
      end
    join
    i = fb(hk, 1'b1);
    chk("exit_wait", 1, i >= 0 && fc(3'h1) - i >= 3);
    chk("acc_after", 1, fb(ha, 1'b1) > i);
    apb(1'b1, REG_MEMCTL, 32'hB);
    watch(20);
    chk("sref_stays", 0, hk[19]);
    rst_n <= 1'b0;
    watch(2);
    rst_n <= 1'b1;
    chk("por_cke", 1, cke);
    apb(1'b0, REG_MEMCTL, '0);
    chk("por_reg", 0, rdat);
    wrap_up();
  end
endmodule // test_sdram_refresh_init_bus_control
